// ---- hdl/rsseq_pkg.sv ----
/*
  Constants, state type and slot helper functions for the regulator
  start-up sequencer. Assumes a 25 MHz system clock.
*/
package rsseq_pkg;

  // regulator index order in every packed slot vector
  localparam int NUM_REG = 7;
  localparam int SLOT_W = 3;
  localparam int SLOTS_W = NUM_REG * SLOT_W;
  localparam int REG_BUCK_ONE = 0;
  localparam int REG_BUCK_TWO = 1;
  localparam int REG_BUCK_THREE = 2;
  localparam int REG_LINEAR_ONE = 3;
  localparam int REG_LINEAR_TWO = 4;
  localparam int REG_LINEAR_THREE = 5;
  localparam int REG_MEM_REF = 6;

  // timing, printed figures and derived cycle counts
  localparam real CLK_KHZ = 25000.0;
  localparam real T_BACKUP_DLY_MS = 0.6;
  localparam real T_SLOT_FAST_MS = 0.5;
  localparam real T_SLOT_SLOW_MS = 2.0;
  localparam real T_RESET_DLY_MS = 2.0;
  localparam real T_DOWN_GAP_MS = 2.0;
  localparam real T_RAMP_STEP_US = 4.0;
  localparam int BACKUP_DLY_CYC = int'($ceil(T_BACKUP_DLY_MS * CLK_KHZ));
  localparam int SLOT_FAST_CYC = int'($ceil(T_SLOT_FAST_MS * CLK_KHZ));
  localparam int SLOT_SLOW_CYC = int'($ceil(T_SLOT_SLOW_MS * CLK_KHZ));
  localparam int RESET_DLY_CYC = int'($ceil(T_RESET_DLY_MS * CLK_KHZ));
  localparam int DOWN_GAP_CYC = int'($ceil(T_DOWN_GAP_MS * CLK_KHZ));
  localparam int RAMP_STEP_CYC =
    int'($ceil(T_RAMP_STEP_US * CLK_KHZ / 1000.0));
  localparam int TMR_W = 16;

  // register port
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_UP_SLOTS = 8'h08;
  localparam logic [ADDR_W-1:0] ADDR_DN_SLOTS = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_TARGET = 8'h10;
  localparam logic [ADDR_W-1:0] ADDR_RAMP_ONE = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_RAMP_TWO = 8'h18;

  // control and status fields
  localparam int CTRL_PERIOD_BIT = 0;
  localparam int CTRL_UP_BIT = 1;
  localparam int CTRL_DOWN_BIT = 2;
  localparam int STAT_EN_LSB = 0;
  localparam int STAT_BACKUP_BIT = 8;
  localparam int STAT_RESET_BIT = 9;
  localparam int STAT_UP_PEND_BIT = 10;
  localparam int STAT_DN_PEND_BIT = 11;
  localparam int STAT_STATE_LSB = 12;
  localparam int STAT_SLOT_LSB = 16;

  // reset values
  localparam int ADDR7_W = 7;
  localparam int CODE_W = 6;
  localparam logic [SLOTS_W-1:0] UP_SLOTS_REF = 21'h0c_a29c;
  localparam logic [ADDR7_W-1:0] TARGET_ADDR_RST = 7'h08;
  localparam logic [CODE_W-1:0] RAMP_CODE_RST = 6'h00;
  localparam logic [SLOT_W-1:0] SLOT_NONE = 3'h0;
  localparam logic [SLOT_W-1:0] SLOT_FIRST = 3'h1;

  typedef enum logic [2:0] {
    ST_NO_INPUT,
    ST_BACKUP_WAIT,
    ST_OFF,
    ST_UP,
    ST_RESET_WAIT,
    ST_RUN,
    ST_DOWN
  } rsseq_state_e;

  // highest slot value used by any regulator
  function automatic logic [SLOT_W-1:0] slot_max(
    input logic [SLOTS_W-1:0] slots
  );
    logic [SLOT_W-1:0] m;
    m = SLOT_NONE;
    for (int i = 0; i < NUM_REG; i++) begin
      if (slots[i*SLOT_W +: SLOT_W] > m) begin
        m = slots[i*SLOT_W +: SLOT_W];
      end
    end
    return m;
  endfunction : slot_max

  // regulators whose slot equals the given value
  function automatic logic [NUM_REG-1:0] slot_mask(
    input logic [SLOTS_W-1:0] slots,
    input logic [SLOT_W-1:0] value
  );
    logic [NUM_REG-1:0] m;
    m = '0;
    for (int i = 0; i < NUM_REG; i++) begin
      m[i] = (slots[i*SLOT_W +: SLOT_W] == value);
    end
    return m;
  endfunction : slot_mask

endpackage : rsseq_pkg

// ---- hdl/rsseq_timer.sv ----
/*
  One-shot down counter: a load pulse starts it, expire pulses once
  when the loaded count has elapsed. Assumes one clock and sync reset.
*/
`timescale 1ns/1ps
module rsseq_timer
  import rsseq_pkg::*;
#(
  parameter int CNT_W = TMR_W
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // control
  input wire logic load,
  input wire logic [CNT_W-1:0] load_val,
  // event
  output logic expire
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic run;
    logic expire;
  } rsseq_tmr_s;

  rsseq_tmr_s st;
  rsseq_tmr_s next_st;

  always_comb begin
    next_st = st;
    next_st.expire = 1'b0;
    if (load) begin
      next_st.cnt = load_val;
      next_st.run = 1'b1;
    end else if (st.run) begin
      // expire lands load_val cycles after the load edge
      if (st.cnt <= CNT_W'(1)) begin
        next_st.run = 1'b0;
        next_st.expire = 1'b1;
      end else begin
        next_st.cnt = st.cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign expire = st.expire;

endmodule : rsseq_timer

// ---- hdl/rsseq_ramp.sv ----
/*
  Output-voltage ramp for one buck: the code moves one step (one
  12.5 mV increment) toward the target every STEP_CYC clocks.
  Assumes one clock and sync reset.
*/
`timescale 1ns/1ps
module rsseq_ramp
  import rsseq_pkg::*;
#(
  parameter int W = CODE_W,
  parameter int STEP_CYC = RAMP_STEP_CYC
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // target
  input wire logic [W-1:0] target,
  // ramped output
  output logic [W-1:0] code,
  output logic busy
);

  localparam int TICK_W = $clog2(STEP_CYC + 1);

  typedef struct packed {
    logic [W-1:0] code;
    logic [TICK_W-1:0] tick;
  } rsseq_ramp_s;

  rsseq_ramp_s st;
  rsseq_ramp_s next_st;

  always_comb begin
    next_st = st;
    if (st.code == target) begin
      next_st.tick = '0;
    end else if (st.tick == TICK_W'(STEP_CYC - 1)) begin
      next_st.tick = '0;
      if (target > st.code) begin
        next_st.code = st.code + W'(1);
      end else begin
        next_st.code = st.code - W'(1);
      end
    end else begin
      next_st.tick = st.tick + TICK_W'(1);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '{code: RAMP_CODE_RST, tick: '0};
    end else begin
      st <= next_st;
    end
  end

  assign code = st.code;
  assign busy = (st.code != target);

endmodule : rsseq_ramp

// ---- hdl/rsseq_top.sv ----
/*
  Regulator start-up sequencer: backup supply turn-on, slotted power-up
  of seven regulators, processor reset release, reverse power-down and
  buck voltage ramps, with a simple register port.
  Assumes clk_sys at 25 MHz, srst synchronous active high, and inputs
  synchronous to clk_sys.
*/
`timescale 1ns/1ps
module rsseq_top
  import rsseq_pkg::*;
#(
  parameter int BACKUP_DELAY = BACKUP_DLY_CYC,
  parameter int SLOT_FAST = SLOT_FAST_CYC,
  parameter int SLOT_SLOW = SLOT_SLOW_CYC,
  parameter int RESET_RELEASE_DELAY = RESET_DLY_CYC,
  parameter int DOWN_GAP = DOWN_GAP_CYC,
  parameter int RAMP_STEP = RAMP_STEP_CYC,
  parameter logic [SLOTS_W-1:0] STARTUP_SLOTS = UP_SLOTS_REF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // supply input monitor
  input wire logic input_valid,
  // register port
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rd_data,
  // supplies and reset toward the processor
  output logic backup_supply_out,
  output logic [NUM_REG-1:0] reg_enable,
  output logic processor_reset_out_n,
  // buck voltage codes and bus address
  output logic [CODE_W-1:0] buck_one_vcode,
  output logic [CODE_W-1:0] buck_two_vcode,
  output logic [ADDR7_W-1:0] target_address
);

  typedef struct packed {
    rsseq_state_e state;
    logic [SLOT_W-1:0] slot;
    logic [NUM_REG-1:0] en;
    logic backup;
    logic rst_n;
    logic period_sel;
    logic up_pend;
    logic dn_pend;
    logic [SLOTS_W-1:0] dn_slots;
    logic [ADDR7_W-1:0] tgt_addr;
    logic [CODE_W-1:0] ramp_one;
    logic [CODE_W-1:0] ramp_two;
    logic [DATA_W-1:0] rdata;
  } rsseq_top_s;

  rsseq_top_s st;
  rsseq_top_s next_st;

  logic tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic tmr_expire;
  logic ramp_one_busy;
  logic ramp_two_busy;
  logic [CODE_W-1:0] vcode_one;
  logic [CODE_W-1:0] vcode_two;
  logic [SLOT_W-1:0] up_last;
  logic [SLOT_W-1:0] dn_last;
  logic [TMR_W-1:0] slot_gap;
  logic [DATA_W-1:0] rd_mux;

  // last start-up slot and last shutdown slot in use
  assign up_last = slot_max(STARTUP_SLOTS);
  assign dn_last = slot_max(st.dn_slots);
  assign slot_gap = st.period_sel ? TMR_W'(SLOT_SLOW)
                                  : TMR_W'(SLOT_FAST);

  rsseq_timer #(
    .CNT_W(TMR_W)
  ) u_timer (
    .clk_sys(clk_sys),
    .srst(srst),
    .load(tmr_load),
    .load_val(tmr_val),
    .expire(tmr_expire)
  );

  rsseq_ramp #(
    .W(CODE_W),
    .STEP_CYC(RAMP_STEP)
  ) u_ramp_one (
    .clk_sys(clk_sys),
    .srst(srst),
    .target(st.ramp_one),
    .code(vcode_one),
    .busy(ramp_one_busy)
  );

  rsseq_ramp #(
    .W(CODE_W),
    .STEP_CYC(RAMP_STEP)
  ) u_ramp_two (
    .clk_sys(clk_sys),
    .srst(srst),
    .target(st.ramp_two),
    .code(vcode_two),
    .busy(ramp_two_busy)
  );

  // read multiplexer, unmapped addresses read zero
  always_comb begin
    rd_mux = '0;
    case (addr)
      ADDR_CTRL: begin
        rd_mux[CTRL_PERIOD_BIT] = st.period_sel;
        rd_mux[CTRL_UP_BIT] = st.up_pend;
        rd_mux[CTRL_DOWN_BIT] = st.dn_pend;
      end
      ADDR_STATUS: begin
        rd_mux[STAT_EN_LSB +: NUM_REG] = st.en;
        rd_mux[STAT_BACKUP_BIT] = st.backup;
        rd_mux[STAT_RESET_BIT] = st.rst_n;
        rd_mux[STAT_UP_PEND_BIT] = ramp_one_busy;
        rd_mux[STAT_DN_PEND_BIT] = ramp_two_busy;
        rd_mux[STAT_STATE_LSB +: 3] = st.state;
        rd_mux[STAT_SLOT_LSB +: SLOT_W] = st.slot;
      end
      ADDR_UP_SLOTS: begin
        rd_mux[SLOTS_W-1:0] = STARTUP_SLOTS;
      end
      ADDR_DN_SLOTS: begin
        rd_mux[SLOTS_W-1:0] = st.dn_slots;
      end
      ADDR_TARGET: begin
        rd_mux[ADDR7_W-1:0] = st.tgt_addr;
      end
      ADDR_RAMP_ONE: begin
        rd_mux[CODE_W-1:0] = vcode_one;
      end
      ADDR_RAMP_TWO: begin
        rd_mux[CODE_W-1:0] = vcode_two;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  always_comb begin
    next_st = st;
    tmr_load = 1'b0;
    tmr_val = slot_gap;
    next_st.rdata = rd_en ? rd_mux : '0;

    // register writes; requests stay pending until taken, except up requests written in ST_UP to ST_RUN, which are dropped
    if (wr_en) begin
      case (addr)
        ADDR_CTRL: begin
          next_st.period_sel = wr_data[CTRL_PERIOD_BIT];
          if (wr_data[CTRL_UP_BIT]) begin
            next_st.up_pend = 1'b1;
          end
          if (wr_data[CTRL_DOWN_BIT]) begin
            next_st.dn_pend = 1'b1;
          end
        end
        ADDR_DN_SLOTS: begin
          next_st.dn_slots = wr_data[SLOTS_W-1:0];
        end
        ADDR_TARGET: begin
          next_st.tgt_addr = wr_data[ADDR7_W-1:0];
        end
        ADDR_RAMP_ONE: begin
          next_st.ramp_one = wr_data[CODE_W-1:0];
        end
        ADDR_RAMP_TWO: begin
          next_st.ramp_two = wr_data[CODE_W-1:0];
        end
        default: begin
        end
      endcase
    end

    case (st.state)
      ST_NO_INPUT: begin
        if (input_valid) begin
          tmr_load = 1'b1;
          tmr_val = TMR_W'(BACKUP_DELAY);
          next_st.state = ST_BACKUP_WAIT;
        end
      end
      ST_BACKUP_WAIT: begin
        if (tmr_expire) begin
          next_st.backup = 1'b1;
          next_st.state = ST_OFF;
        end
      end
      ST_OFF: begin
        // power-up only after the backup supply is on
        if (st.up_pend) begin
          next_st.up_pend = 1'b0;
          next_st.rst_n = 1'b0;
          next_st.slot = SLOT_FIRST;
          // slot-zero regulators never match a started slot
          next_st.en = st.en | slot_mask(STARTUP_SLOTS, SLOT_FIRST);
          tmr_load = 1'b1;
          if (up_last <= SLOT_FIRST) begin
            tmr_val = TMR_W'(RESET_RELEASE_DELAY);
            next_st.state = ST_RESET_WAIT;
          end else begin
            tmr_val = slot_gap;
            next_st.state = ST_UP;
          end
        end
      end
      ST_UP: begin
        if (tmr_expire) begin
          next_st.slot = st.slot + SLOT_FIRST;
          next_st.en = st.en |
            slot_mask(STARTUP_SLOTS, st.slot + SLOT_FIRST);
          tmr_load = 1'b1;
          if (st.slot + SLOT_FIRST >= up_last) begin
            tmr_val = TMR_W'(RESET_RELEASE_DELAY);
            next_st.state = ST_RESET_WAIT;
          end else begin
            tmr_val = slot_gap;
          end
        end
      end
      ST_RESET_WAIT: begin
        if (tmr_expire) begin
          next_st.rst_n = 1'b1;
          next_st.up_pend = 1'b0;
          next_st.state = ST_RUN;
        end
      end
      ST_RUN: begin
        next_st.up_pend = 1'b0;
        if (st.dn_pend) begin
          next_st.dn_pend = 1'b0;
          next_st.rst_n = 1'b0;
          if (dn_last == SLOT_NONE) begin
            next_st.en = '0;
            next_st.slot = SLOT_NONE;
            next_st.state = ST_OFF;
          end else begin
            next_st.slot = dn_last;
            next_st.en = st.en & ~slot_mask(st.dn_slots, dn_last);
            tmr_load = 1'b1;
            tmr_val = TMR_W'(DOWN_GAP);
            next_st.state = ST_DOWN;
          end
        end
      end
      ST_DOWN: begin
        if (tmr_expire) begin
          next_st.slot = st.slot - SLOT_FIRST;
          if (st.slot == SLOT_FIRST) begin
            // slot-zero leftovers go with the last step
            next_st.en = '0;
            next_st.state = ST_OFF;
          end else begin
            next_st.en = st.en &
              ~slot_mask(st.dn_slots, st.slot - SLOT_FIRST);
            tmr_load = 1'b1;
            tmr_val = TMR_W'(DOWN_GAP);
          end
        end
      end
      default: begin
        next_st.state = ST_NO_INPUT;
      end
    endcase

    // losing the input drops the enables, backup supply, reset and pending requests at once
    if (!input_valid) begin
      next_st.state = ST_NO_INPUT;
      next_st.en = '0;
      next_st.backup = 1'b0;
      next_st.rst_n = 1'b0;
      next_st.slot = SLOT_NONE;
      next_st.up_pend = 1'b0;
      next_st.dn_pend = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      st <= '{
        state: ST_NO_INPUT,
        slot: SLOT_NONE,
        en: '0,
        backup: 1'b0,
        rst_n: 1'b0,
        period_sel: 1'b0,
        up_pend: 1'b0,
        dn_pend: 1'b0,
        dn_slots: STARTUP_SLOTS,
        tgt_addr: TARGET_ADDR_RST,
        ramp_one: RAMP_CODE_RST,
        ramp_two: RAMP_CODE_RST,
        rdata: '0
      };
    end else begin
      st <= next_st;
    end
  end

  assign rd_data = st.rdata;
  assign backup_supply_out = st.backup;
  assign reg_enable = st.en;
  assign processor_reset_out_n = st.rst_n;
  assign buck_one_vcode = vcode_one;
  assign buck_two_vcode = vcode_two;
  assign target_address = st.tgt_addr;

endmodule : rsseq_top

// ---- verif/rsseq_assertions.sv ----
/*
  Checker for the regulator start-up sequencer, bound to rsseq_top.
  Assumes the top hands on its timing parameters through the bind.
*/
`timescale 1ns/1ps
module rsseq_checker
  import rsseq_pkg::*;
#(
  parameter int BACKUP_DELAY = BACKUP_DLY_CYC,
  parameter int SLOT_FAST = SLOT_FAST_CYC,
  parameter int SLOT_SLOW = SLOT_SLOW_CYC,
  parameter int RESET_RELEASE_DELAY = RESET_DLY_CYC,
  parameter int DOWN_GAP = DOWN_GAP_CYC,
  parameter int RAMP_STEP = RAMP_STEP_CYC
) (
  // clock, reset, input monitor
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic input_valid,
  // watched outputs
  input wire logic backup_supply_out,
  input wire logic [NUM_REG-1:0] reg_enable,
  input wire logic processor_reset_out_n,
  input wire logic [CODE_W-1:0] buck_one_vcode,
  input wire logic [ADDR7_W-1:0] target_address
);
  logic [NUM_REG-1:0] prev_en;
  logic [CODE_W-1:0] prev_v1;
  logic [15:0] vcnt;
  logic [15:0] ecnt;
  logic [15:0] rcnt;

  // ages: valid input, enable pattern, ramp code
  always_ff @(posedge clk_sys) begin
    prev_en <= reg_enable;
    prev_v1 <= buck_one_vcode;
    if (srst || !input_valid) begin
      vcnt <= 16'h0000;
    end else if (vcnt != 16'hffff) begin
      vcnt <= vcnt + 16'h0001;
    end
    if (srst || reg_enable != prev_en) begin
      ecnt <= 16'h0001;
    end else if (ecnt != 16'hffff) begin
      ecnt <= ecnt + 16'h0001;
    end
    if (srst || buck_one_vcode != prev_v1) begin
      rcnt <= 16'h0001;
    end else if (rcnt != 16'hffff) begin
      rcnt <= rcnt + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);

  property p_backup_delay;
    $rose(backup_supply_out) |->
      int'(vcnt) >= BACKUP_DELAY && int'(vcnt) <= BACKUP_DELAY + 4;
  endproperty
  a_backup_delay: assert property (p_backup_delay)
    else $error("backup supply on at wrong time");
  property p_backup_first;
    reg_enable != '0 |-> backup_supply_out;
  endproperty
  a_backup_first: assert property (p_backup_first)
    else $error("regulator on before backup supply");
  property p_slot_gap;
    (reg_enable & ~$past(reg_enable)) != '0 && $past(reg_enable) != '0 |->
      (int'(ecnt) >= SLOT_FAST - 2 && int'(ecnt) <= SLOT_FAST + 2) ||
      (int'(ecnt) >= SLOT_SLOW - 2 && int'(ecnt) <= SLOT_SLOW + 2);
  endproperty
  a_slot_gap: assert property (p_slot_gap)
    else $error("start slot spacing wrong");
  property p_reset_hold;
    $rose(processor_reset_out_n) |-> reg_enable != '0 &&
      int'(ecnt) >= RESET_RELEASE_DELAY - 2 &&
      int'(ecnt) <= RESET_RELEASE_DELAY + 3;
  endproperty
  a_reset_hold: assert property (p_reset_hold)
    else $error("processor reset released at wrong time");
  property p_reset_low_seq;
    (reg_enable & ~$past(reg_enable)) != '0 |-> !processor_reset_out_n;
  endproperty
  a_reset_low_seq: assert property (p_reset_low_seq)
    else $error("processor reset released during start-up");
  property p_down_gap;
    ($past(reg_enable) & ~reg_enable) != '0 && input_valid &&
      $past(input_valid) && !$past(processor_reset_out_n, 2) |->
      int'(ecnt) >= DOWN_GAP - 2 && int'(ecnt) <= DOWN_GAP + 2;
  endproperty
  a_down_gap: assert property (p_down_gap)
    else $error("power-down spacing wrong");
  property p_target;
    $fell(srst) |-> target_address == 7'h08;
  endproperty
  a_target: assert property (p_target)
    else $error("target address not at default after reset");
  property p_ramp;
    $changed(buck_one_vcode) |-> int'(rcnt) >= RAMP_STEP - 1 &&
      (buck_one_vcode - $past(buck_one_vcode) == 6'h01 ||
       buck_one_vcode - $past(buck_one_vcode) == 6'h3f);
  endproperty
  a_ramp: assert property (p_ramp)
    else $error("buck code step size or rate wrong");
  property p_input_loss;
    !input_valid ##1 !input_valid |-> reg_enable == '0 &&
      !processor_reset_out_n && !backup_supply_out;
  endproperty
  a_input_loss: assert property (p_input_loss)
    else $error("outputs not cleared without input");
endmodule : rsseq_checker

bind rsseq_top rsseq_checker #(.BACKUP_DELAY(BACKUP_DELAY),
  .SLOT_FAST(SLOT_FAST), .SLOT_SLOW(SLOT_SLOW),
  .RESET_RELEASE_DELAY(RESET_RELEASE_DELAY), .DOWN_GAP(DOWN_GAP),
  .RAMP_STEP(RAMP_STEP)) rsseq_checker_inst (.clk_sys(clk_sys),
  .srst(srst), .input_valid(input_valid),
  .backup_supply_out(backup_supply_out), .reg_enable(reg_enable),
  .processor_reset_out_n(processor_reset_out_n),
  .buck_one_vcode(buck_one_vcode), .target_address(target_address));

// ---- verif/rsseq_cpu_model.sv ----
/*
  Processor-side model: counts boots that leave reset with every
  supply up. Assumes it only watches the sequencer outputs.
*/
`timescale 1ns/1ps
module rsseq_cpu_model
  import rsseq_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // supplies and reset from the sequencer
  input wire logic backup_supply_out,
  input wire logic [NUM_REG-1:0] reg_enable,
  input wire logic processor_reset_out_n,
  // clean boot count
  output logic [7:0] boots
);
  logic prev_rst_n = 1'b0;
  initial boots = 8'h00;
  always @(posedge clk_sys) begin
    prev_rst_n <= processor_reset_out_n;
    if (processor_reset_out_n && !prev_rst_n && backup_supply_out &&
        reg_enable == 7'h7f) begin
      boots <= boots + 8'h01;
    end
  end
endmodule : rsseq_cpu_model

// ---- verif/testbench.sv ----
/*
  Bench for the regulator start-up sequencer: three start and stop runs,
  register reads and a buck ramp. Assumes the shortened timing below.
*/
`timescale 1ns/1ps
module testbench;
  import rsseq_pkg::*;
  localparam int BKD = 20;
  localparam int SF = 10;
  localparam int SS = 40;
  localparam int RRD = 30;
  localparam int DG = 25;
  localparam int RS = 4;
  logic clk_sys = 1'b0;
  logic srst;
  logic input_valid;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wr_data;
  logic wr_en;
  logic rd_en;
  logic [DATA_W-1:0] rd_data;
  logic backup_supply_out;
  logic [NUM_REG-1:0] reg_enable;
  logic processor_reset_out_n;
  logic [CODE_W-1:0] buck_one_vcode;
  logic [CODE_W-1:0] buck_two_vcode;
  logic [ADDR7_W-1:0] target_address;
  logic [7:0] boots;
  int fails = 0;
  int check_count = 0;

  always #20 clk_sys = ~clk_sys;

  rsseq_top #(.BACKUP_DELAY(BKD), .SLOT_FAST(SF), .SLOT_SLOW(SS),
    .RESET_RELEASE_DELAY(RRD), .DOWN_GAP(DG), .RAMP_STEP(RS))
  rsseq_top_inst (.clk_sys(clk_sys), .srst(srst), .input_valid(input_valid),
    .addr(addr), .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en),
    .rd_data(rd_data), .backup_supply_out(backup_supply_out),
    .reg_enable(reg_enable), .processor_reset_out_n(processor_reset_out_n),
    .buck_one_vcode(buck_one_vcode), .buck_two_vcode(buck_two_vcode),
    .target_address(target_address));

  rsseq_cpu_model rsseq_cpu_model_inst (.clk_sys(clk_sys),
    .backup_supply_out(backup_supply_out), .reg_enable(reg_enable),
    .processor_reset_out_n(processor_reset_out_n), .boots(boots));

  task automatic check(input string name, input logic [31:0] seen,
    input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test

  task automatic wr_reg(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= v;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [31:0] e,
    input string name);
    @(posedge clk_sys);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    @(negedge clk_sys);
    check(name, rd_data, e);
  endtask : rd_chk

  // 0 enables, 1 processor reset, 2 backup, 3 buck one code
  function automatic logic [6:0] cur(input int sel);
    case (sel)
      0: return reg_enable;
      1: return {6'h00, processor_reset_out_n};
      2: return {6'h00, backup_supply_out};
      default: return {1'b0, buck_one_vcode};
    endcase
  endfunction : cur

  // wait for a value, then check how many cycles it took
  task automatic wait_for(input int sel, input logic [6:0] m,
    input int lo, input int hi, input string name);
    int k;
    k = 0;
    while (cur(sel) !== m && k < 2000) begin
      @(negedge clk_sys);
      k++;
    end
    check(name, {25'h0, cur(sel)}, {25'h0, m});
    check({name, " delay"}, {31'h0, k >= lo && k <= hi}, 32'h1);
    if (k >= 2000) begin
      stop_test();
    end
  endtask : wait_for

  task automatic power_up(input logic slow, input int g);
    wr_reg(ADDR_CTRL, {30'h0, 1'b1, slow});
    wait_for(0, 7'h28, 0, 4, "slot one");
    wait_for(0, 7'h3c, g - 2, g + 2, "slot two");
    wait_for(0, 7'h7e, g - 2, g + 2, "slot three");
    wait_for(0, 7'h7f, g - 2, g + 2, "slot four");
    check("reset held", {31'h0, processor_reset_out_n}, 32'h0);
    wait_for(1, 7'h01, RRD - 2, RRD + 3, "reset release");
  endtask : power_up

  initial begin
    srst = 1'b1;
    input_valid = 1'b0;
    addr = '0;
    wr_data = '0;
    wr_en = 1'b0;
    rd_en = 1'b0;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    @(negedge clk_sys);
    check("target address", {25'h0, target_address}, 32'h8);
    rd_chk(ADDR_TARGET, 32'h0000_0008, "target reg");
    rd_chk(ADDR_UP_SLOTS, 32'h000c_a29c, "startup slots");
    rd_chk(ADDR_DN_SLOTS, 32'h000c_a29c, "shutdown slots");
    rd_chk(8'hfc, 32'h0000_0000, "unmapped");
    @(posedge clk_sys);
    input_valid <= 1'b1;
    wait_for(2, 7'h01, BKD - 2, BKD + 4, "backup on");
    check("early enables", {25'h0, reg_enable}, 32'h0);
    power_up(1'b0, SF);
    wr_reg(ADDR_RAMP_TWO, 32'h0000_0002);
    wr_reg(ADDR_RAMP_ONE, 32'h0000_0003);
    wait_for(3, 7'h03, 3 * RS - 2, 3 * RS + 3, "ramp up");
    check("buck two code", {26'h0, buck_two_vcode}, 32'h2);
    rd_chk(ADDR_RAMP_TWO, 32'h0000_0002, "ramp two reg");
    wr_reg(ADDR_RAMP_ONE, 32'h0000_0001);
    wait_for(3, 7'h01, 2 * RS - 2, 2 * RS + 3, "ramp down");
    wr_reg(ADDR_CTRL, 32'h0000_0004);
    wait_for(0, 7'h7e, 0, 4, "down four");
    wait_for(0, 7'h3c, DG - 2, DG + 2, "down three");
    wait_for(0, 7'h28, DG - 2, DG + 2, "down two");
    wait_for(0, 7'h00, DG - 2, DG + 2, "down one");
    // one more gap after slot one before the sequencer is off
    repeat (DG + 2) @(posedge clk_sys);
    rd_chk(ADDR_STATUS, 32'h0000_2100, "status off");
    power_up(1'b1, SS);
    wr_reg(ADDR_DN_SLOTS, 32'h0001_94d1);
    wr_reg(ADDR_CTRL, 32'h0000_0005);
    wait_for(0, 7'h5b, 0, 4, "custom three");
    wait_for(0, 7'h51, DG - 2, DG + 2, "custom two");
    wait_for(0, 7'h40, DG - 2, DG + 2, "custom one");
    wait_for(0, 7'h00, DG - 2, DG + 2, "custom zero");
    power_up(1'b0, SF);
    wr_reg(ADDR_DN_SLOTS, 32'h0000_0000);
    wr_reg(ADDR_CTRL, 32'h0000_0004);
    wait_for(0, 7'h00, 0, 4, "bypass");
    check("clean boots", {24'h0, boots}, 32'h3);
    @(posedge clk_sys);
    input_valid <= 1'b0;
    wait_for(2, 7'h00, 0, 4, "backup off");
    stop_test();
  end
endmodule : testbench
